// ### logic/irq_ctrl_pkg.sv
// register map, field positions and reset values of the interrupt controller
package irq_ctrl_pkg;
    localparam logic [11:0] OFS_BASIC_PEND  = 12'h200;
    localparam logic [11:0] OFS_PEND_LOW    = 12'h204;
    localparam logic [11:0] OFS_PEND_HIGH   = 12'h208;
    localparam logic [11:0] OFS_FAST_SEL    = 12'h20c;
    localparam logic [11:0] OFS_EN_SET_LOW  = 12'h210;
    localparam logic [11:0] OFS_EN_SET_HIGH = 12'h214;
    localparam logic [11:0] OFS_EN_SET_BAS  = 12'h218;
    localparam logic [11:0] OFS_EN_CLR_LOW  = 12'h21c;
    localparam logic [11:0] OFS_EN_CLR_HIGH = 12'h220;
    localparam logic [11:0] OFS_EN_CLR_BAS  = 12'h224;
    localparam logic [11:0] OFS_CONTROL1    = 12'h228;
    localparam int          ADDR_W          = 12;
    localparam int          FAST_EN_BIT     = 7;
    localparam int          HALT_ROUTE_BIT  = 10;
    localparam int          SUM_LOW_BIT     = 8;
    localparam int          SUM_HIGH_BIT    = 9;
    localparam logic [6:0]  FAST_SEL_LOCAL  = 7'h40;
    localparam logic [6:0]  FAST_SEL_LAST   = 7'h47;
    localparam logic [31:0] DIRECT_MASK_LOW  = 32'h000c_0680;
    localparam logic [31:0] DIRECT_MASK_HIGH = 32'h43e0_0000;
    localparam logic [31:0] RESET_VALUE     = 32'h0000_0000;
    localparam logic [1:0]  RESP_OKAY       = 2'b00;
    localparam logic [1:0]  RESP_SLVERR     = 2'b10;
    localparam int          LOC_HALT0       = 4;
    localparam int          LOC_HALT1       = 5;
endpackage : irq_ctrl_pkg

// ### logic/irq_pending_enable_fiq_ctrl.sv
// interrupt controller: pending words, enable set/clear, fast interrupt routing
// Operation
// - sources 0..31 pending readable at 0x204
// - bit 8 summarises non-direct low sources
// - sources 32..63 pending readable at 0x208
// - bit 9 summarises non-direct high sources
// - fast select bits 6:0, enable bit 7
// - fast output off while enable clear
// - select 0..63 picks graphics source
// - select 64..71 picks local sources
// - low set word sets enables 0..31
// - high set word sets enables 32..63
// - pending visible only when enabled
// - basic set word sets local enables
// - local enable bit order fixed
// - local pending visible only when enabled
// - low clear word clears enables 0..31
// - high clear word clears enables 32..63
// - basic clear word clears local enables
// - basic pending word layout
// - control bit 10 routes halt1 into halt0
`timescale 1ns/100ps
module irq_pending_enable_fiq_ctrl
    import irq_ctrl_pkg::*;
(
    input  wire logic        sys_clk_i,
    input  wire logic        rst_b_i,
    input  wire logic [63:0] gpu_irq_i,
    input  wire logic [7:0]  local_irq_i,
    input  wire logic [11:0] s_axi_awaddr_i,
    input  wire logic        s_axi_awvalid_i,
    output logic             s_axi_awready_o,
    input  wire logic [31:0] s_axi_wdata_i,
    input  wire logic [3:0]  s_axi_wstrb_i,
    input  wire logic        s_axi_wvalid_i,
    output logic             s_axi_wready_o,
    output logic [1:0]       s_axi_bresp_o,
    output logic             s_axi_bvalid_o,
    input  wire logic        s_axi_bready_i,
    input  wire logic [11:0] s_axi_araddr_i,
    input  wire logic        s_axi_arvalid_i,
    output logic             s_axi_arready_o,
    output logic [31:0]      s_axi_rdata_o,
    output logic [1:0]       s_axi_rresp_o,
    output logic             s_axi_rvalid_o,
    input  wire logic        s_axi_rready_i,
    output logic             irq_o,
    output logic             fiq_o
);

    // ************************************************************
    // write channel capture
    // ************************************************************
    logic [11:0] aw_addr;
    logic        aw_held;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        w_held;
    logic        wr_fire;
    logic [31:0] wr_mask;

    assign s_axi_awready_o = !aw_held && !s_axi_bvalid_o;
    assign s_axi_wready_o  = !w_held && !s_axi_bvalid_o;
    assign wr_fire         = aw_held && w_held;

    // address and data may arrive in either order; each is parked until both are here
    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            aw_held <= 1'b0;
            w_held  <= 1'b0;
            aw_addr <= '0;
            w_data  <= RESET_VALUE;
            w_strb  <= '0;
        end else if (wr_fire) begin
            aw_held <= 1'b0;
            w_held  <= 1'b0;
        end else begin
            if (s_axi_awvalid_i && s_axi_awready_o) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr_i;
            end
            if (s_axi_wvalid_i && s_axi_wready_o) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata_i;
                w_strb <= s_axi_wstrb_i;
            end
        end
    end

    // byte enables gate which written ones take effect
    always_comb begin
        for (int b = 0; b < 4; b++) begin
            wr_mask[8*b +: 8] = w_data[8*b +: 8] & {8{w_strb[b]}};
        end
    end

    // ************************************************************
    // write response
    // ************************************************************
    logic wr_hit;

    always_comb begin
        unique case (aw_addr)
            OFS_FAST_SEL, OFS_EN_SET_LOW, OFS_EN_SET_HIGH, OFS_EN_SET_BAS,
            OFS_EN_CLR_LOW, OFS_EN_CLR_HIGH, OFS_EN_CLR_BAS, OFS_CONTROL1: wr_hit = 1'b1;
            default: wr_hit = 1'b0;
        endcase
    end

    // read-only and unmapped words answer slverr; writes to them change nothing
    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            s_axi_bvalid_o <= 1'b0;
            s_axi_bresp_o  <= RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid_o <= 1'b1;
            s_axi_bresp_o  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready_i) begin
            s_axi_bvalid_o <= 1'b0;
        end
    end

    // ************************************************************
    // enable bits and control registers
    // ************************************************************
    logic [63:0] gpu_enable;
    logic [7:0]  local_enable;
    logic [7:0]  fast_sel;
    logic        halt_route;

    // one write touches one word, so set and clear never collide in a cycle
    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            gpu_enable <= '0;
        end else if (wr_fire) begin
            if (aw_addr == OFS_EN_SET_LOW)  gpu_enable[31:0]  <= gpu_enable[31:0] | wr_mask;
            if (aw_addr == OFS_EN_SET_HIGH) gpu_enable[63:32] <= gpu_enable[63:32] | wr_mask;
            if (aw_addr == OFS_EN_CLR_LOW)  gpu_enable[31:0]  <= gpu_enable[31:0] & ~wr_mask;
            if (aw_addr == OFS_EN_CLR_HIGH) gpu_enable[63:32] <= gpu_enable[63:32] & ~wr_mask;
        end
    end

    // local enable bit n gates local source n: timer..access error type 0
    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            local_enable <= '0;
        end else if (wr_fire) begin
            if (aw_addr == OFS_EN_SET_BAS) local_enable <= local_enable | wr_mask[7:0];
            if (aw_addr == OFS_EN_CLR_BAS) local_enable <= local_enable & ~wr_mask[7:0];
        end
    end

    // fast select and the halt routing control
    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            fast_sel   <= '0;
            halt_route <= 1'b0;
        end else if (wr_fire) begin
            if (aw_addr == OFS_FAST_SEL && w_strb[0]) fast_sel <= w_data[7:0];
            if (aw_addr == OFS_CONTROL1 && w_strb[1]) halt_route <= w_data[HALT_ROUTE_BIT];
        end
    end

    // ************************************************************
    // pending words
    // ************************************************************
    logic [7:0]  local_raw;
    logic [63:0] gpu_vis;
    logic [7:0]  local_vis;
    logic [31:0] basic_word;

    // halt1 also shows on the halt0 position when routing is on
    always_comb begin
        local_raw            = local_irq_i;
        local_raw[LOC_HALT0] = local_irq_i[LOC_HALT0] | (halt_route & local_irq_i[LOC_HALT1]);
    end

    assign gpu_vis   = gpu_irq_i & gpu_enable;
    assign local_vis = local_raw & local_enable;

    // direct copies make the summaries redundant for those sources
    always_comb begin
        basic_word               = '0;
        basic_word[7:0]          = local_vis;
        basic_word[SUM_LOW_BIT]  = |(gpu_vis[31:0] & ~DIRECT_MASK_LOW);
        basic_word[SUM_HIGH_BIT] = |(gpu_vis[63:32] & ~DIRECT_MASK_HIGH);
        basic_word[20:10] = {gpu_vis[62], gpu_vis[57:53], gpu_vis[19:18],
                             gpu_vis[10:9], gpu_vis[7]};
    end

    // level output, no latching inside the block
    assign irq_o = |gpu_vis || |local_vis;

    // ************************************************************
    // fast interrupt routing
    // ************************************************************
    logic fast_src;

    // reserved selects 72..127 give no source at all
    always_comb begin
        if (fast_sel[6] == 1'b0)
            fast_src = gpu_irq_i[fast_sel[5:0]];
        else if (fast_sel[6:0] <= FAST_SEL_LAST)
            fast_src = local_raw[fast_sel[2:0]];
        else
            fast_src = 1'b0;
    end

    assign fiq_o = fast_sel[FAST_EN_BIT] & fast_src;

    // ************************************************************
    // read channel
    // ************************************************************
    logic [31:0] rd_word;
    logic [1:0]  rd_resp;

    always_comb begin
        rd_resp = RESP_OKAY;
        unique case (s_axi_araddr_i)
            OFS_BASIC_PEND: rd_word = basic_word;
            OFS_PEND_LOW:   rd_word = gpu_vis[31:0];
            OFS_PEND_HIGH:  rd_word = gpu_vis[63:32];
            OFS_FAST_SEL:   rd_word = {24'h00_0000, fast_sel};
            OFS_CONTROL1:   rd_word = {21'h00_0000, halt_route, 10'h000};
            OFS_EN_SET_LOW, OFS_EN_SET_HIGH, OFS_EN_SET_BAS,
            OFS_EN_CLR_LOW, OFS_EN_CLR_HIGH, OFS_EN_CLR_BAS: rd_word = RESET_VALUE;
            default: begin
                rd_word = RESET_VALUE;
                rd_resp = RESP_SLVERR;
            end
        endcase
    end

    assign s_axi_arready_o = !s_axi_rvalid_o;

    // data registered at the address handshake, held until rready
    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            s_axi_rvalid_o <= 1'b0;
            s_axi_rdata_o  <= RESET_VALUE;
            s_axi_rresp_o  <= RESP_OKAY;
        end else if (s_axi_arvalid_i && s_axi_arready_o) begin
            s_axi_rvalid_o <= 1'b1;
            s_axi_rdata_o  <= rd_word;
            s_axi_rresp_o  <= rd_resp;
        end else if (s_axi_rready_i) begin
            s_axi_rvalid_o <= 1'b0;
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    property p_fast_off;
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        !fast_sel[FAST_EN_BIT] |-> !fiq_o;
    endproperty
    a_fast_off: assert property (p_fast_off) else $error("fast out while disabled");

    property p_fast_gpu;
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        (fast_sel[FAST_EN_BIT] && !fast_sel[6]) |-> fiq_o == gpu_irq_i[fast_sel[5:0]];
    endproperty
    a_fast_gpu: assert property (p_fast_gpu) else $error("fast gpu route wrong");

    property p_fast_timer;
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        (fast_sel == 8'hc0) |-> fiq_o == local_irq_i[0];
    endproperty
    a_fast_timer: assert property (p_fast_timer) else $error("fast timer route wrong");

    property p_set_low;
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        (wr_fire && aw_addr == OFS_EN_SET_LOW) |=> ((gpu_enable[31:0] & $past(wr_mask))
            == $past(wr_mask)) && ((gpu_enable[31:0] & ~$past(wr_mask))
            == (32'($past(gpu_enable)) & ~$past(wr_mask)));
    endproperty
    a_set_low: assert property (p_set_low) else $error("low set wrong");

    property p_clr_high;
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        (wr_fire && aw_addr == OFS_EN_CLR_HIGH) |=> (gpu_enable[63:32] & $past(wr_mask)) == 0;
    endproperty
    a_clr_high: assert property (p_clr_high) else $error("high clear wrong");

    property p_set_high;
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        (wr_fire && aw_addr == OFS_EN_SET_HIGH) |=> (gpu_enable[63:32] & $past(wr_mask)) == $past(wr_mask);
    endproperty
    a_set_high: assert property (p_set_high) else $error("high set wrong");

    property p_clr_low;
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        (wr_fire && aw_addr == OFS_EN_CLR_LOW) |=> (gpu_enable[31:0] & $past(wr_mask)) == 32'h0;
    endproperty
    a_clr_low: assert property (p_clr_low) else $error("low clear wrong");

    // only the low byte of the written word reaches the eight local enables
    property p_local_set;
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        (wr_fire && aw_addr == OFS_EN_SET_BAS) |=> (local_enable & 8'($past(wr_mask))) == 8'($past(wr_mask));
    endproperty
    a_local_set: assert property (p_local_set) else $error("local set wrong");

    property p_local_clr;
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        (wr_fire && aw_addr == OFS_EN_CLR_BAS && wr_mask[0]) |=> !basic_word[0];
    endproperty
    a_local_clr: assert property (p_local_clr) else $error("timer still visible");

    property p_hidden;
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        (gpu_enable == 64'h0 && local_enable == 8'h00) |-> !irq_o && basic_word == 0;
    endproperty
    a_hidden: assert property (p_hidden) else $error("disabled source visible");

    property p_summary_low;
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        (gpu_vis[31:0] == DIRECT_MASK_LOW) |-> !basic_word[SUM_LOW_BIT] && basic_word[14:10] == 5'h1f;
    endproperty
    a_summary_low: assert property (p_summary_low) else $error("low summary wrong");

    property p_summary_high;
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        (gpu_vis[63:32] == DIRECT_MASK_HIGH) |-> !basic_word[SUM_HIGH_BIT] && basic_word[20:15] == 6'h3f;
    endproperty
    a_summary_high: assert property (p_summary_high) else $error("high summary wrong");

    property p_halt_route;
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        (halt_route && local_enable[LOC_HALT0] && local_irq_i[LOC_HALT1]) |-> basic_word[4];
    endproperty
    a_halt_route: assert property (p_halt_route) else $error("halt route missing");

    property p_read_answer;
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        (s_axi_arvalid_i && s_axi_arready_o) |=> s_axi_rvalid_o;
    endproperty
    a_read_answer: assert property (p_read_answer) else $error("read not answered");

    c_fast_on: cover property (@(posedge sys_clk_i) disable iff (!rst_b_i) fiq_o);
    c_irq_on:  cover property (@(posedge sys_clk_i) disable iff (!rst_b_i) irq_o);
    c_write:   cover property (@(posedge sys_clk_i) disable iff (!rst_b_i) wr_fire && wr_hit);
    c_sum:     cover property (@(posedge sys_clk_i) disable iff (!rst_b_i) basic_word[9]);

endmodule : irq_pending_enable_fiq_ctrl

// ### verif/host_core_model.sv
// host core model: watches the interrupt lines as a processor core would
`timescale 1ns/100ps
module host_core_model (
    input  wire logic       sys_clk_i,
    input  wire logic       rst_b_i,
    input  wire logic       irq_i,
    input  wire logic       fiq_i,
    output logic      [7:0] irq_rises_o,
    output logic      [7:0] fiq_rises_o
);
    logic irq_prev;
    logic fiq_prev;

    // counts entries into each handler; a level held high counts once only
    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            irq_prev    <= 1'b0;
            fiq_prev    <= 1'b0;
            irq_rises_o <= '0;
            fiq_rises_o <= '0;
        end else begin
            irq_prev    <= irq_i;
            fiq_prev    <= fiq_i;
            irq_rises_o <= irq_rises_o + 8'((irq_i && !irq_prev) ? 1 : 0);
            fiq_rises_o <= fiq_rises_o + 8'((fiq_i && !fiq_prev) ? 1 : 0);
        end
    end
endmodule : host_core_model

// ### verif/testbench.sv
// self-checking bench of the interrupt controller over its register bus
`timescale 1ns/100ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin fail_count++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); end end
module testbench;
    import irq_ctrl_pkg::*;
    logic        sys_clk = 1'b0;
    logic        rst_b = 1'b0;
    logic [63:0] gpu_irq = '0;
    logic [7:0]  local_irq = '0;
    logic [11:0] awaddr = '0;
    logic [11:0] araddr = '0;
    logic [31:0] wdata = '0;
    logic [3:0]  wstrb = 4'hf;
    logic        awvalid = 1'b0;
    logic        wvalid = 1'b0;
    logic        arvalid = 1'b0;
    logic        bready = 1'b1;
    logic        rready = 1'b1;
    wire logic   awready, wready, bvalid, arready, rvalid, irq, fiq;
    wire logic [1:0]  bresp, rresp;
    wire logic [31:0] rdata;
    wire logic [7:0]  fiq_rises;
    wire logic [7:0]  irq_rises;
    int          fail_count = 0;
    int          check_count = 0;
    int          cycles = 0;

    always #2 sys_clk = ~sys_clk;

    irq_pending_enable_fiq_ctrl dut_u (.sys_clk_i(sys_clk), .rst_b_i(rst_b),
        .gpu_irq_i(gpu_irq), .local_irq_i(local_irq), .s_axi_awaddr_i(awaddr),
        .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
        .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
        .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
        .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
        .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
        .s_axi_rready_i(rready), .irq_o(irq), .fiq_o(fiq));

    host_core_model host_u (.sys_clk_i(sys_clk), .rst_b_i(rst_b), .irq_i(irq),
        .fiq_i(fiq), .irq_rises_o(irq_rises), .fiq_rises_o(fiq_rises));

    // ************************************************************
    // bus tasks
    // ************************************************************
    task automatic tick();
        @(posedge sys_clk);
    endtask : tick

    // address and data offered together; each dropped at its own handshake
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
        logic aw_ok;
        logic w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge sys_clk);
            if (!aw_ok && awready) begin
                aw_ok = 1'b1;
                awvalid <= 1'b0;
            end
            if (!w_ok && wready) begin
                w_ok = 1'b1;
                wvalid <= 1'b0;
            end
        end
        while (bvalid !== 1'b1) @(posedge sys_clk);
        `CHK(bresp, r)
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
        araddr <= a;
        arvalid <= 1'b1;
        @(posedge sys_clk);
        while (arready !== 1'b1) @(posedge sys_clk);
        arvalid <= 1'b0;
        @(posedge sys_clk);
        while (rvalid !== 1'b1) @(posedge sys_clk);
        `CHK(rresp, r)
        `CHK(rdata, d)
    endtask : rd

    task automatic finish_test();
        $display("mismatches %0d comparisons %0d", fail_count, check_count);
        if (fail_count == 0 && check_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : finish_test

    // ************************************************************
    // scenarios
    // ************************************************************
    task automatic test_reset_map();
        for (int o = 'h200; o <= 'h224; o += 4) rd(12'(o), RESET_VALUE, RESP_OKAY);
        rd(12'h22c, 32'h0, RESP_SLVERR);
        wr(OFS_PEND_LOW, 32'hffff_ffff, RESP_SLVERR);
    endtask : test_reset_map

    // direct sources must not raise the summary bits, others must
    task automatic test_enables();
        gpu_irq <= '1;
        wr(OFS_EN_SET_LOW, 32'h000c_0680, RESP_OKAY);
        rd(OFS_PEND_LOW, 32'h000c_0680, RESP_OKAY);
        rd(OFS_BASIC_PEND, 32'h0000_7c00, RESP_OKAY);
        wr(OFS_EN_SET_LOW, 32'h0000_0001, RESP_OKAY);
        rd(OFS_BASIC_PEND, 32'h0000_7d00, RESP_OKAY);
        wr(OFS_EN_SET_HIGH, 32'h43e0_0000, RESP_OKAY);
        rd(OFS_BASIC_PEND, 32'h001f_fd00, RESP_OKAY);
        wr(OFS_EN_SET_HIGH, 32'h0000_0001, RESP_OKAY);
        rd(OFS_PEND_HIGH, 32'h43e0_0001, RESP_OKAY);
        rd(OFS_BASIC_PEND, 32'h001f_ff00, RESP_OKAY);
        tick();
        `CHK(irq, 1'b1)
        gpu_irq <= '0;
        tick();
        `CHK(irq, 1'b0)
        gpu_irq <= '1;
        wr(OFS_EN_CLR_LOW, 32'h0000_0081, RESP_OKAY);
        rd(OFS_PEND_LOW, 32'h000c_0600, RESP_OKAY);
        wr(OFS_EN_CLR_HIGH, 32'hffff_fffe, RESP_OKAY);
        rd(OFS_PEND_HIGH, 32'h0000_0001, RESP_OKAY);
        wr(OFS_EN_CLR_LOW, 32'hffff_ffff, RESP_OKAY);
        wr(OFS_EN_CLR_HIGH, 32'hffff_ffff, RESP_OKAY);
        rd(OFS_BASIC_PEND, 32'h0000_0000, RESP_OKAY);
        tick();
        `CHK(irq, 1'b0)
    endtask : test_enables

    task automatic test_local();
        gpu_irq <= '0;
        local_irq <= '1;
        wr(OFS_EN_SET_BAS, 32'h0000_00a5, RESP_OKAY);
        rd(OFS_BASIC_PEND, 32'h0000_00a5, RESP_OKAY);
        wr(OFS_EN_CLR_BAS, 32'h0000_0085, RESP_OKAY);
        rd(OFS_BASIC_PEND, 32'h0000_0020, RESP_OKAY);
        wr(OFS_EN_SET_BAS, 32'h0000_00ff, RESP_OKAY);
        for (int k = 0; k < 8; k++) begin
            local_irq <= 8'(1 << k);
            rd(OFS_BASIC_PEND, 32'(1) << k, RESP_OKAY);
        end
        wr(OFS_EN_CLR_BAS, 32'h0000_00ef, RESP_OKAY);
        local_irq <= 8'h20;
        rd(OFS_BASIC_PEND, 32'h0000_0000, RESP_OKAY);
        // routing bit sits in byte 1, so a byte 0 only write must not reach it
        wstrb <= 4'h1;
        wr(OFS_CONTROL1, 32'h0000_0400, RESP_OKAY);
        rd(OFS_BASIC_PEND, 32'h0000_0000, RESP_OKAY);
        wstrb <= 4'hf;
        wr(OFS_CONTROL1, 32'h0000_0400, RESP_OKAY);
        rd(OFS_BASIC_PEND, 32'h0000_0010, RESP_OKAY);
        tick();
        `CHK(irq, 1'b1)
        wr(OFS_CONTROL1, 32'h0000_0000, RESP_OKAY);
        wr(OFS_EN_CLR_BAS, 32'h0000_00ff, RESP_OKAY);
        local_irq <= '0;
    endtask : test_local

    // inputs are cleared before each select write so every entry counts once
    task automatic test_fast();
        int sel[6] = '{0, 1, 31, 32, 62, 63};
        for (int i = 0; i < 14; i++) begin
            gpu_irq <= '0;
            local_irq <= '0;
            wr(OFS_FAST_SEL, 32'h80 | 32'((i < 6) ? sel[i] : 58 + i), RESP_OKAY);
            rd(OFS_FAST_SEL, 32'h80 | 32'((i < 6) ? sel[i] : 58 + i), RESP_OKAY);
            if (i < 6) gpu_irq <= 64'(1) << sel[i];
            else local_irq <= 8'(1 << (i - 6));
            tick();
            `CHK(fiq, 1'b1)
            if (i < 6) gpu_irq <= ~(64'(1) << sel[i]);
            else local_irq <= ~8'(1 << (i - 6));
            tick();
            `CHK(fiq, 1'b0)
        end
        // select 71 with only its own source low: every other line high must not leak
        wr(OFS_FAST_SEL, 32'hffff_ffc7, RESP_OKAY);
        rd(OFS_FAST_SEL, 32'h0000_00c7, RESP_OKAY);
        gpu_irq <= '1;
        local_irq <= 8'h7f;
        tick();
        `CHK(fiq, 1'b0)
        wr(OFS_FAST_SEL, 32'h0000_003f, RESP_OKAY);
        tick();
        `CHK(fiq, 1'b0)
        `CHK(fiq_rises, 8'd14)
        `CHK(irq_rises, 8'd4)
    endtask : test_fast

    // hang guard, far above the few hundred cycles the run needs
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fail_count++;
            finish_test();
        end
    end

    initial begin
        repeat (16) @(posedge sys_clk);
        rst_b <= 1'b1;
        @(posedge sys_clk);
        test_reset_map();
        test_enables();
        test_local();
        test_fast();
        finish_test();
    end
endmodule : testbench
